// [design/notice_flag.sv]
// One notice bit with its set and clear policy.
// Assumes raise and clear inputs are synchronous to i_clock.
`timescale 1ns/10ps
module notice_flag #(
    parameter bit STICKY_CLEAR = 1'b0
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_raise,
    input wire logic i_clear_cond,
    input wire logic i_auto_clear,
    input wire logic i_clear_req,
    output logic o_flag,
    output logic o_rise
);
    logic flag_ff;
    logic rise_ff;
    logic cond_ff;
    logic cond_eff;

    // Event-type clear conditions are remembered until the next raise
    assign cond_eff = i_clear_cond | (STICKY_CLEAR & cond_ff);

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cond_ff <= 1'b0;
        end else if (i_raise) begin
            cond_ff <= 1'b0;
        end else if (i_clear_cond) begin
            cond_ff <= 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flag_ff <= 1'b0; // R5
        end else if (i_raise) begin
            flag_ff <= 1'b1;
        end else if (flag_ff && cond_eff && (i_auto_clear || i_clear_req)) begin
            flag_ff <= 1'b0; // R1 R2 R3
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rise_ff <= 1'b0;
        end else begin
            rise_ff <= i_raise & ~flag_ff;
        end
    end

    assign o_flag = flag_ff;
    assign o_rise = rise_ff;
endmodule

// [design/notice_flag_manager.sv]
// Notice flag manager: notice bits, combined output, history, AHB-Lite registers.
// Assumes monitor inputs come from logic on I_CLOCK; pin inputs are asynchronous.
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
module notice_flag_manager
    import notice_pkg::*;
#(
    parameter int TICK_CYCLES = TIME_TICK_CYCLES
) (
    input wire logic I_CLOCK,
    input wire logic I_RST_B,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    input wire logic I_NOTICE_CLEAR_INPUT,
    input wire logic I_HOME_ALL_INPUT,
    input wire logic I_HOME_ROBOT_INPUT,
    input wire logic I_PRESET_INPUT,
    input wire logic [255:0] I_USER_OUTPUTS,
    input wire logic I_COORDS_SET_OUTPUT,
    input wire monitor_type I_MONITOR,
    input wire limit_type I_LIMITS,
    input wire logic [NUM_AXES-1:0] I_MECH_MISMATCH,
    input wire logic I_START_REQ,
    input wire logic I_START_DIR_POS,
    input wire logic I_READY,
    input wire logic I_START_OK,
    input wire logic I_ORIGIN_REWRITTEN,
    input wire logic I_SERIAL_ERR,
    input wire logic I_SERIAL_OK,
    output logic [NUM_NOTICES-1:0] O_NOTICE_BITS,
    output logic O_NOTICE_ANY_OUTPUT
);
    if (TICK_CYCLES < 1) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 1");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] pin_raw;
    logic [NUM_PINS-1:0] pin_meta_ff;
    logic [NUM_PINS-1:0] pin_sync_ff;
    logic [NUM_PINS-1:0] pin_prev_ff;
    logic [NUM_PINS-1:0] pin_edge;

    assign pin_raw = {I_PRESET_INPUT, I_HOME_ROBOT_INPUT, I_HOME_ALL_INPUT, I_NOTICE_CLEAR_INPUT};

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
            pin_prev_ff <= '0;
        end else begin
            pin_meta_ff <= pin_raw;
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    assign pin_edge = pin_sync_ff & ~pin_prev_ff;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic auto_clear_ff;
    logic mismatch_en_ff;
    logic clr_notice_ff;
    logic clr_hist_ff;
    logic [7:0] usrio_sel_ff;
    logic [7:0] temp_limit_ff;
    logic [31:0] tool_limit_ff;
    logic [3:0] hist_sel_ff;
    logic [NUM_AXES-1:0][31:0] axis_limit_ff;
    logic addr_valid;
    logic [31:0] rd_mux;
    logic [NUM_NOTICES-1:0] notice;
    logic [4:0] hist_count_ff;
    hist_entry_type hist_rd;

    // Sub-word writes land in the whole word; only word transfers are used
    assign addr_valid = I_HSEL & I_HREADY & (I_HTRANS == HTRANS_NONSEQ);

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_valid & I_HWRITE;
            wr_addr_ff <= I_HADDR[7:0];
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            auto_clear_ff <= 1'b1;
            mismatch_en_ff <= 1'b1;
            clr_notice_ff <= 1'b0;
            clr_hist_ff <= 1'b0;
            usrio_sel_ff <= USRIO_SEL_RST;
            temp_limit_ff <= TEMP_LIMIT_RST;
            tool_limit_ff <= '0;
            hist_sel_ff <= 4'h0;
            axis_limit_ff <= '0;
        end else begin
            clr_notice_ff <= 1'b0;
            clr_hist_ff <= 1'b0;
            if (wr_pend_ff) begin
                case (wr_addr_ff)
                    ADDR_CTRL: begin
                        auto_clear_ff <= I_HWDATA[CTRL_AUTO_CLEAR];
                        mismatch_en_ff <= I_HWDATA[CTRL_MISMATCH_EN];
                        clr_notice_ff <= I_HWDATA[CTRL_CLR_NOTICE];
                        clr_hist_ff <= I_HWDATA[CTRL_CLR_HIST];
                    end
                    ADDR_USRIO_SEL: usrio_sel_ff <= I_HWDATA[7:0];
                    ADDR_TEMP_LIMIT: temp_limit_ff <= I_HWDATA[7:0];
                    ADDR_TOOL_LIMIT: tool_limit_ff <= I_HWDATA;
                    ADDR_HIST_SEL: hist_sel_ff <= I_HWDATA[3:0];
                    default: begin
                        for (int i = 0; i < NUM_AXES; i++) begin
                            if (wr_addr_ff == ADDR_AXIS_LIMIT + 8'(4 * i)) begin
                                axis_limit_ff[i] <= I_HWDATA;
                            end
                        end
                    end
                endcase
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (I_HADDR[7:0])
            ADDR_CTRL: begin
                rd_mux[CTRL_AUTO_CLEAR] = auto_clear_ff;
                rd_mux[CTRL_MISMATCH_EN] = mismatch_en_ff;
            end
            ADDR_USRIO_SEL: rd_mux[7:0] = usrio_sel_ff;
            ADDR_TEMP_LIMIT: rd_mux[7:0] = temp_limit_ff;
            ADDR_TOOL_LIMIT: rd_mux = tool_limit_ff;
            ADDR_STATUS: rd_mux[NUM_NOTICES-1:0] = notice;
            ADDR_HIST_COUNT: rd_mux[4:0] = hist_count_ff;
            ADDR_HIST_SEL: rd_mux[3:0] = hist_sel_ff;
            ADDR_HIST_CODE: rd_mux = {11'h000, hist_rd.item, hist_rd.code}; // R8
            ADDR_HIST_TIME: rd_mux = hist_rd.stamp;
            default: begin
                for (int i = 0; i < NUM_AXES; i++) begin
                    if (I_HADDR[7:0] == ADDR_AXIS_LIMIT + 8'(4 * i)) begin
                        rd_mux = axis_limit_ff[i];
                    end
                end
            end
        endcase
    end

    // Read data is prepared at the address phase so the slave needs no wait state
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_valid && !I_HWRITE) begin
            hrdata_ff <= rd_mux;
        end
    end

    assign O_HRDATA = hrdata_ff;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = 1'b0;

    // ------------------------------------------------------------
    // Notice conditions
    // ------------------------------------------------------------
    logic [NUM_NOTICES-1:0] raise;
    logic [NUM_NOTICES-1:0] clear_cond;
    logic [NUM_NOTICES-1:0] rise;
    logic [NUM_AXES-1:0] axis_over;
    logic [NUM_AXES-1:0] axis_under;
    logic pos_blocked;
    logic neg_blocked;
    logic usr_on;
    logic clear_req;

    for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
        assign axis_over[a] = (axis_limit_ff[a] != '0)
            && (I_MONITOR.axis_speed[a] > axis_limit_ff[a]);
        assign axis_under[a] = (axis_limit_ff[a] == '0)
            || (I_MONITOR.axis_speed[a] < axis_limit_ff[a]);
    end

    assign usr_on = I_USER_OUTPUTS[usrio_sel_ff];
    assign pos_blocked = (|I_LIMITS.tool_pos_over) | (|I_LIMITS.axis_pos_over);
    assign neg_blocked = (|I_LIMITS.tool_neg_over) | (|I_LIMITS.axis_neg_over);
    assign clear_req = pin_sync_ff[P_CLEAR] | clr_notice_ff; // R4

    always_comb begin
        raise[N_USER_IO] = usr_on; // R10
        clear_cond[N_USER_IO] = ~usr_on;
        raise[N_TEMP] = I_MONITOR.temp > temp_limit_ff; // R11
        clear_cond[N_TEMP] = I_MONITOR.temp < temp_limit_ff;
        raise[N_TOOL_SPD] = (tool_limit_ff != '0) && (I_MONITOR.tool_speed > tool_limit_ff); // R12
        clear_cond[N_TOOL_SPD] = (tool_limit_ff == '0) || (I_MONITOR.tool_speed < tool_limit_ff);
        raise[N_AXIS_SPD] = |axis_over; // R13
        clear_cond[N_AXIS_SPD] = &axis_under;
        raise[N_START] = I_START_REQ
            && (!I_READY || (I_START_DIR_POS ? pos_blocked : neg_blocked)); // R14
        clear_cond[N_START] = I_START_OK;
        raise[N_HOMING] = (pin_edge[P_HOME_ALL] | pin_edge[P_HOME_ROBOT])
            & ~I_COORDS_SET_OUTPUT; // R15
        clear_cond[N_HOMING] = I_START_OK;
        raise[N_PRESET] = pin_edge[P_PRESET]; // R16
        clear_cond[N_PRESET] = I_ORIGIN_REWRITTEN;
        raise[N_MISMATCH] = mismatch_en_ff & (|I_MECH_MISMATCH); // R17
        clear_cond[N_MISMATCH] = ~|I_MECH_MISMATCH;
        raise[N_SERIAL] = I_SERIAL_ERR; // R18
        clear_cond[N_SERIAL] = I_SERIAL_OK;
        raise[N_TOOL_POS] = |I_LIMITS.tool_pos_over; // R19
        clear_cond[N_TOOL_POS] = ~|I_LIMITS.tool_pos_over;
        raise[N_TOOL_NEG] = |I_LIMITS.tool_neg_over;
        clear_cond[N_TOOL_NEG] = ~|I_LIMITS.tool_neg_over;
        raise[N_AXIS_POS] = |I_LIMITS.axis_pos_over; // R20
        clear_cond[N_AXIS_POS] = ~|I_LIMITS.axis_pos_over;
        raise[N_AXIS_NEG] = |I_LIMITS.axis_neg_over;
        clear_cond[N_AXIS_NEG] = ~|I_LIMITS.axis_neg_over;
    end

    // Event clears (start, homing, preset, serial) are remembered until the next raise
    for (genvar n = 0; n < NUM_NOTICES; n++) begin : g_notice
        localparam bit STICKY = (n == N_START) || (n == N_HOMING)
            || (n == N_PRESET) || (n == N_SERIAL);
        notice_flag #(.STICKY_CLEAR(STICKY)) u_flag (
            .i_clock(I_CLOCK),
            .i_rst_b(I_RST_B),
            .i_raise(raise[n]),
            .i_clear_cond(clear_cond[n]),
            .i_auto_clear(auto_clear_ff),
            .i_clear_req(clear_req),
            .o_flag(notice[n]),
            .o_rise(rise[n])
        );
    end

    assign O_NOTICE_BITS = notice;

    logic any_ff;

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            any_ff <= 1'b0;
        end else begin
            any_ff <= |notice; // R21 R22
        end
    end

    assign O_NOTICE_ANY_OUTPUT = any_ff;

    // ------------------------------------------------------------
    // Notice history
    // ------------------------------------------------------------
    hist_entry_type hist_mem [HIST_DEPTH];
    logic [3:0] wptr_ff;
    logic [NUM_NOTICES-1:0] pend_ff;
    logic [NUM_NOTICES-1:0] grant;
    logic [4:0] grant_idx;
    logic push;
    logic [31:0] stamp_ff;
    logic [31:0] tick_ff;
    logic [3:0] rd_ptr;

    always_comb begin
        grant = '0;
        grant_idx = 5'h00;
        for (int i = NUM_NOTICES - 1; i >= 0; i--) begin
            if (pend_ff[i]) begin
                grant = '0;
                grant[i] = 1'b1;
                grant_idx = 5'(i);
            end
        end
    end

    assign push = (|pend_ff) & ~clr_hist_ff;

    // New rises are kept even when a grant or a history clear lands in the same cycle
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pend_ff <= '0;
        end else if (clr_hist_ff) begin
            pend_ff <= rise;
        end else begin
            pend_ff <= (pend_ff & ~grant) | rise;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            tick_ff <= '0;
            stamp_ff <= '0;
        end else if (tick_ff == 32'(TICK_CYCLES - 1)) begin
            tick_ff <= '0;
            stamp_ff <= stamp_ff + 32'h0000_0001;
        end else begin
            tick_ff <= tick_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            wptr_ff <= 4'h0;
            hist_count_ff <= 5'h00; // R9
        end else if (clr_hist_ff) begin
            wptr_ff <= 4'h0;
            hist_count_ff <= 5'h00; // R8
        end else if (push) begin
            wptr_ff <= wptr_ff + 4'h1; // R6
            if (hist_count_ff != 5'(HIST_DEPTH)) begin
                hist_count_ff <= hist_count_ff + 5'h01;
            end
        end
    end

    // Storage needs no reset: the count alone says what is valid
    always_ff @(posedge I_CLOCK) begin
        if (push) begin
            hist_mem[wptr_ff] <= '{code: NOTICE_CODE_BASE + 16'(grant_idx),
                                   item: grant_idx, stamp: stamp_ff}; // R7
        end
    end

    // Selector 0 is the newest entry
    assign rd_ptr = wptr_ff - 4'h1 - hist_sel_ff;
    assign hist_rd = ({1'b0, hist_sel_ff} < hist_count_ff) ? hist_mem[rd_ptr] : '0;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RST_B);

    sequence s_usr_held;
        notice[N_USER_IO] && !auto_clear_ff && !usr_on;
    endsequence

    a_auto_drop: assert property (notice[N_TEMP] && auto_clear_ff && clear_cond[N_TEMP]
        && !raise[N_TEMP] |=> !notice[N_TEMP]) // R1
        else $error("auto clear did not drop notice");
    a_manual_hold: assert property (s_usr_held ##0 !clear_req |=> notice[N_USER_IO]) // R2
        else $error("notice dropped without clear request");
    a_clear_guard: assert property (notice[N_TEMP] && !clear_cond[N_TEMP]
        |=> notice[N_TEMP]) // R3
        else $error("notice cleared while condition unmet");
    a_clear_pin: assert property (s_usr_held ##0 pin_sync_ff[P_CLEAR]
        |=> !notice[N_USER_IO]) // R4
        else $error("clear input ignored");
    a_any_follow: assert property (O_NOTICE_ANY_OUTPUT == $past(|notice)) // R22
        else $error("combined output wrong");
    a_any_drop: assert property ($fell(|notice) |=> !O_NOTICE_ANY_OUTPUT) // R21
        else $error("combined output stuck after clear");
    a_hist_bound: assert property (hist_count_ff <= 5'(HIST_DEPTH)) // R6
        else $error("history count overflow");
    a_hist_push: assert property (push && hist_count_ff < 5'(HIST_DEPTH)
        |=> hist_count_ff == $past(hist_count_ff) + 5'h01) // R6
        else $error("history push not counted");
    a_hist_clear: assert property (clr_hist_ff |=> hist_count_ff == 5'h00) // R8
        else $error("history clear failed");
    a_start_err: assert property (I_START_REQ && !I_READY |=> notice[N_START]) // R14
        else $error("start error not raised");
    a_axis_raise: assert property (|axis_over |=> notice[N_AXIS_SPD]) // R13
        else $error("axis speed notice not raised");
    a_rise_logged: assert property (rise[N_SERIAL] && !clr_hist_ff
        |=> pend_ff[N_SERIAL]) // R7
        else $error("raised notice not queued for history");
endmodule

// [design/notice_pkg.sv]
// Constants, field layouts and carrier types for the notice flag manager.
// Assumes a single 10 MHz system clock and an AHB-Lite register bus.
//
// Overview of operation
// (R1) Auto-clear on: a raised notice drops by itself once its clear condition holds.
// (R2) Auto-clear off: a raised notice stays up until a clear request arrives.
// (R3) A clear request only drops a notice whose clear condition holds now, or, for event notices, has held since the raise.
// (R4) The clear input pin acts as a clear request, like the clear command.
// (R5) All notice bits are low after power-on reset.
// (R6) History keeps 16 newest notices, newest first, dropping the oldest when full.
// (R7) Each history entry holds notice code, raise time and notice item.
// (R8) History is readable by register and emptied by a clear command.
// (R9) History is volatile and empty after every power-up.
// (R10) User-I/O notice follows the selected output signal being on.
// (R11) Over-temperature notice above threshold; clear condition below threshold.
// (R12) Tool speed notice above limit; clear condition below limit.
// (R13) Axis speed notice when any axis is over; clear needs all below.
// (R14) Start error on start toward a limited direction or while not ready.
// (R15) Homing start error on homing input while coordinates are not set.
// (R16) Preset request notice on preset input; clear once origin is rewritten.
// (R17) With mismatch reporting on, raise mismatch notice while mechanism differs.
// (R18) Serial link error notice on link error; clear after a good exchange.
// (R19) Tool limit notices per direction: any of X, Y, Z over; clear when all within.
// (R20) Axis limit notices per direction: any axis over; clear when all within.
// (R21) Auto clear drops the notice bit and the combined output if no other holds it.
// (R22) Combined notice output is high while any notice bit is raised.
package notice_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int TIME_TICK_NS = 1000000;
    localparam int TIME_TICK_CYCLES = TIME_TICK_NS / CLK_PERIOD_NS;
    localparam int NUM_AXES = 8;
    localparam int NUM_NOTICES = 13;
    localparam int HIST_DEPTH = 16;
    localparam int NUM_PINS = 4;
    // Notice items
    localparam int N_USER_IO = 0;
    localparam int N_TEMP = 1;
    localparam int N_TOOL_SPD = 2;
    localparam int N_AXIS_SPD = 3;
    localparam int N_START = 4;
    localparam int N_HOMING = 5;
    localparam int N_PRESET = 6;
    localparam int N_MISMATCH = 7;
    localparam int N_SERIAL = 8;
    localparam int N_TOOL_POS = 9;
    localparam int N_TOOL_NEG = 10;
    localparam int N_AXIS_POS = 11;
    localparam int N_AXIS_NEG = 12;
    // Pin positions in the synchroniser
    localparam int P_CLEAR = 0;
    localparam int P_HOME_ALL = 1;
    localparam int P_HOME_ROBOT = 2;
    localparam int P_PRESET = 3;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_USRIO_SEL = 8'h04;
    localparam logic [7:0] ADDR_TEMP_LIMIT = 8'h08;
    localparam logic [7:0] ADDR_TOOL_LIMIT = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_HIST_COUNT = 8'h14;
    localparam logic [7:0] ADDR_HIST_SEL = 8'h18;
    localparam logic [7:0] ADDR_HIST_CODE = 8'h1C;
    localparam logic [7:0] ADDR_HIST_TIME = 8'h20;
    localparam logic [7:0] ADDR_AXIS_LIMIT = 8'h40;
    // Control fields
    localparam int CTRL_AUTO_CLEAR = 0;
    localparam int CTRL_MISMATCH_EN = 1;
    localparam int CTRL_CLR_NOTICE = 8;
    localparam int CTRL_CLR_HIST = 9;
    localparam int HC_ITEM_LSB = 16;
    localparam logic [7:0] TEMP_LIMIT_RST = 8'h55;
    localparam logic [7:0] USRIO_SEL_RST = 8'h00;
    localparam logic [15:0] NOTICE_CODE_BASE = 16'h0100;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [7:0] temp;
        logic [31:0] tool_speed;
        logic [NUM_AXES-1:0][31:0] axis_speed;
    } monitor_type;

    typedef struct packed {
        logic [2:0] tool_pos_over;
        logic [2:0] tool_neg_over;
        logic [NUM_AXES-1:0] axis_pos_over;
        logic [NUM_AXES-1:0] axis_neg_over;
    } limit_type;

    typedef struct packed {
        logic [15:0] code;
        logic [4:0] item;
        logic [31:0] stamp;
    } hist_entry_type;
endpackage

// [sim/host_model.sv]
// Host partner: AHB-Lite master issuing single word transfers.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/10ps
module host_model
    import notice_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    output logic o_hsel,
    output logic [31:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [31:0] o_hwdata
);
    initial begin
        {o_hsel, o_haddr, o_htrans, o_hwrite, o_hwdata} = '0;
    end
    // Clear and history commands travel through this one task
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge i_clk);
        o_hsel <= 1'b1;
        o_htrans <= HTRANS_NONSEQ;
        o_haddr <= {24'h0, a};
        o_hwrite <= w;
        do @(posedge i_clk); while (i_hready !== 1'b1);
        o_htrans <= 2'h0;
        o_hwdata <= d;
        do @(posedge i_clk); while (i_hready !== 1'b1);
        r = i_hrdata;
        o_hsel <= 1'b0;
    endtask
endmodule

// [sim/notice_flag_manager_tb.sv]
// Testbench: notices, clear policy and history against a queue model.
// Assumes the host model drives the register bus.
`timescale 1ns/10ps
module notice_flag_manager_tb
    import notice_pkg::*;
;
    logic clk = 0, rst_b = 0, clr = 0, hsel, hwrite, hrdy, hresp, any;
    logic [31:0] haddr, hwdata, hrdata, r, lfsr = 32'h49A2, exp, t0;
    logic [1:0] htrans;
    logic [255:0] uo = '0;
    logic [7:0] mm = '0;
    logic [12:0] bits;
    logic z = 0, mmf = 0, sreq = 0, sok = 0;
    monitor_type mon = '0;
    limit_type lim = '0;
    int num_errors = 0, samples_checked = 0, cyc = 0, i;
    int q[$];
    initial begin
        forever #50 clk = ~clk;
    end
    host_model host_model_inst (.i_clk(clk), .i_hready(hrdy), .i_hrdata(hrdata),
        .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
        .o_hwdata(hwdata));
    notice_flag_manager #(.TICK_CYCLES(4)) notice_flag_manager_inst (
        .I_CLOCK(clk), .I_RST_B(rst_b), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
        .I_HREADY(hrdy), .O_HRDATA(hrdata), .O_HREADYOUT(hrdy), .O_HRESP(hresp),
        .I_NOTICE_CLEAR_INPUT(clr), .I_HOME_ALL_INPUT(z), .I_HOME_ROBOT_INPUT(z),
        .I_PRESET_INPUT(z), .I_USER_OUTPUTS(uo), .I_COORDS_SET_OUTPUT(z),
        .I_MONITOR(mon), .I_LIMITS(lim), .I_MECH_MISMATCH(mm), .I_START_REQ(sreq),
        .I_START_DIR_POS(z), .I_READY(z), .I_START_OK(sok), .I_ORIGIN_REWRITTEN(z),
        .I_SERIAL_ERR(sreq), .I_SERIAL_OK(sok), .O_NOTICE_BITS(bits),
        .O_NOTICE_ANY_OUTPUT(any));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_model_inst.xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a);
        host_model_inst.xfer(1'b0, a, 32'h0, r);
    endtask
    // Ends at a falling edge so outputs are settled when compared
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd(ADDR_STATUS);
        chk(r, 32'h0);
        chk({30'h0, hresp, hrdy}, 32'h1);
        rd(ADDR_HIST_COUNT);
        chk(r, 32'h0);
        wr(ADDR_TEMP_LIMIT, 32'h40);
        for (i = 0; i < 18; i++) begin
            @(posedge clk);
            mon.temp <= 8'h50;
            step(3);
            chk({19'h0, bits}, 32'h2);
            chk({31'h0, any}, 32'h1);
            q.push_front(N_TEMP);
            if (q.size() > HIST_DEPTH) q.pop_back();
            @(posedge clk);
            mon.temp <= 8'h30;
            step(3);
            chk({18'h0, any, bits}, 32'h0);
        end
        rd(ADDR_HIST_COUNT);
        chk(r, q.size());
        exp = {11'h0, 5'(q[0]), NOTICE_CODE_BASE + 16'(q[0])};
        wr(ADDR_HIST_SEL, 32'h0);
        rd(ADDR_HIST_CODE);
        chk(r, exp);
        rd(ADDR_HIST_TIME);
        t0 = r;
        wr(ADDR_HIST_SEL, 32'hF);
        rd(ADDR_HIST_CODE);
        chk(r, exp);
        rd(ADDR_HIST_TIME);
        chk(32'(t0 > r), 32'h1);
        wr(ADDR_CTRL, 32'h202);
        q.delete();
        rd(ADDR_HIST_COUNT);
        chk(r, q.size());
        @(posedge clk);
        mon.temp <= 8'h50;
        step(3);
        @(posedge clk);
        mon.temp <= 8'h30;
        step(3);
        chk({19'h0, bits}, 32'h2);
        // Temperature at the limit: neither raise nor clear condition holds
        @(posedge clk);
        mon.temp <= 8'h40;
        uo <= 256'h1;
        wr(ADDR_CTRL, 32'h102);
        step(2);
        chk({19'h0, bits}, 32'h3);
        @(posedge clk);
        mon.temp <= 8'h30;
        uo <= '0;
        clr <= 1'b1;
        step(5);
        chk({19'h0, bits}, 32'h0);
        @(posedge clk);
        clr <= 1'b0;
        wr(ADDR_CTRL, 32'h3);
        @(posedge clk);
        sreq <= 1'b1;
        @(posedge clk);
        sreq <= 1'b0;
        step(1);
        chk({19'h0, bits}, 32'h110);
        @(posedge clk);
        sok <= 1'b1;
        @(posedge clk);
        sok <= 1'b0;
        step(1);
        chk({19'h0, bits}, 32'h0);
        wr(ADDR_AXIS_LIMIT, 32'h10);
        @(posedge clk);
        mon.axis_speed[0] <= 32'h20;
        step(1);
        chk({19'h0, bits}, 32'h8);
        @(posedge clk);
        mon.axis_speed[0] <= 32'h0;
        step(1);
        chk({19'h0, bits}, 32'h0);
        for (i = 0; i < 24; i++) begin
            if (i == 16) wr(ADDR_CTRL, 32'h1);
            lfsr = nxt(lfsr);
            @(posedge clk);
            mm <= lfsr[7:0];
            uo <= {255'h0, lfsr[8]};
            step(3);
            // Turning reporting off does not drop a raised mismatch notice
            mmf = (|mm) & ((i < 16) | mmf);
            exp = {24'h0, mmf, 6'h0, uo[0]};
            chk({19'h0, bits}, exp);
        end
        report_and_stop();
    end
endmodule
